// File: tcoc_pkg.sv
`default_nettype none

package tcoc_pkg;

  // register byte addresses on the APB
  localparam logic [7:0] ADDR_OUT_MODE = 8'h00;
  localparam logic [7:0] ADDR_CLK_MODE = 8'h04;
  localparam logic [7:0] ADDR_COUNTER = 8'h08;
  localparam logic [7:0] ADDR_CMP_A = 8'h0C;
  localparam logic [7:0] ADDR_CMP_B = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE = 8'h14;
  localparam logic [7:0] ADDR_FLAGS = 8'h18;

  // field positions
  localparam int COM_A_LSB = 6;
  localparam int COM_B_LSB = 4;
  localparam int WGM_LOW_LSB = 0;
  localparam int WGM_HIGH_LSB = 3;
  localparam int CLK_SEL_LSB = 0;
  localparam int FLAG_MATCH_A = 0;
  localparam int FLAG_MATCH_B = 1;
  localparam int FLAG_OVF = 2;

  // writable bits and reset values
  localparam logic [7:0] OUT_MODE_MASK = 8'hF3;
  localparam logic [7:0] CLK_MODE_MASK = 8'h1F;
  localparam logic [7:0] OUT_MODE_RESET = 8'h00;
  localparam logic [7:0] CLK_MODE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // counter limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // prescaler tick masks: tick when the low bits are all ones
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03F;
  localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

  // mode codes named in the output tables
  localparam logic [3:0] CODE_PFC_CMPA = 4'hF - 4'h6;
  localparam logic [3:0] CODE_FAST_CAP = 4'hE;
  localparam logic [3:0] CODE_FAST_CMPA = 4'hF;

  typedef enum logic [2:0] {FAM_NORMAL, FAM_CTC, FAM_FAST, FAM_PC, FAM_PFC} tcoc_family_type;
  typedef enum logic [1:0] {TOP_FIXED, TOP_CAPTURE, TOP_CMP_A, TOP_FULL} tcoc_topsrc_type;

  // waveform family of a four-bit code; reserved 13 counts as normal
  function automatic tcoc_family_type tcoc_family(input logic [3:0] code);
    tcoc_family_type fam;
    fam = FAM_NORMAL;
    unique case (code)
      4'h0, 4'hD: fam = FAM_NORMAL;
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: fam = FAM_PC;
      4'h4, 4'hC: fam = FAM_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: fam = FAM_FAST;
      4'h8, 4'h9: fam = FAM_PFC;
    endcase
    return fam;
  endfunction

  // where TOP comes from for a code
  function automatic tcoc_topsrc_type tcoc_topsrc(input logic [3:0] code);
    tcoc_topsrc_type src;
    src = TOP_FULL;
    unique case (code)
      4'h0, 4'hD: src = TOP_FULL;
      4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7: src = TOP_FIXED;
      4'h8, 4'hA, 4'hC, 4'hE: src = TOP_CAPTURE;
      4'h4, 4'h9, 4'hB, 4'hF: src = TOP_CMP_A;
    endcase
    return src;
  endfunction

endpackage

`default_nettype wire

// File: tcoc_wave_chan.sv
`default_nettype none

// one compare-output channel: match detect, pin takeover, waveform flop
module tcoc_wave_chan
  import tcoc_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire tcoc_family_type family,
  input wire logic [3:0] mode_code,
  input wire logic [1:0] out_mode,
  input wire logic [15:0] counter,
  input wire logic [15:0] compare,
  input wire logic [15:0] top,
  input wire logic count_up,
  output logic match,
  output logic connect,
  output logic wave_ff
);

  logic nxt_wave;
  logic nonpwm;
  logic dual;
  logic at_top;
  logic toggle_ok;

  // decode of the family and of the toggle exception
  assign match = (counter == compare);
  assign at_top = (counter == top);
  assign nonpwm = (family == FAM_NORMAL) || (family == FAM_CTC);
  assign dual = (family == FAM_PC) || (family == FAM_PFC);
  assign toggle_ok = IS_CHAN_A &&
    (((family == FAM_FAST) && (mode_code == CODE_FAST_CMPA)) ||
     (dual && ((mode_code == CODE_PFC_CMPA) || (mode_code == CODE_FAST_CAP))));

  // pin takeover; toggle in PWM is only connected where it is allowed
  assign connect = (out_mode != 2'h0) && (nonpwm || out_mode[1] || toggle_ok);

  // next waveform level; out_mode[0] is the level given on match
  always_comb begin
    nxt_wave = wave_ff;
    if (!tick || (out_mode == 2'h0)) begin
      nxt_wave = wave_ff;
    end else if (nonpwm) begin
      if (match) begin
        nxt_wave = (out_mode == 2'h1) ? ~wave_ff : out_mode[0];
      end
    end else if (out_mode == 2'h1) begin
      if (match && toggle_ok) begin
        nxt_wave = ~wave_ff;
      end
    end else if (family == FAM_FAST) begin
      // top wins so a compare equal to TOP never clears the pulse
      if (at_top) begin
        nxt_wave = ~out_mode[0];
      end else if (match) begin
        nxt_wave = out_mode[0];
      end
    end else if (match) begin
      if (compare == top) begin
        nxt_wave = ~out_mode[0];
      end else if (compare == CNT_BOTTOM) begin
        nxt_wave = out_mode[0];
      end else begin
        nxt_wave = count_up ? out_mode[0] : ~out_mode[0];
      end
    end
  end

  // waveform register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_ff <= 1'b0;
    end else begin
      wave_ff <= nxt_wave;
    end
  end

endmodule

`default_nettype wire

// File: tcoc_timer16.sv
`default_nettype none

// 16-bit timer with two compare outputs behind an APB slave
module tcoc_timer16
  import tcoc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_pin,
  input wire logic port_data_a,
  input wire logic port_data_b,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_connect_a,
  output logic wave_connect_b,
  output logic pin_out_a,
  output logic pin_out_b
);

  logic rst_meta_ff;
  logic rst_n;
  logic ext_meta_ff;
  logic ext_sync_ff;
  logic ext_last_ff;
  logic [7:0] out_mode_ff;
  logic [7:0] clk_mode_ff;
  logic [15:0] counter_ff;
  logic [15:0] nxt_counter;
  logic count_up_ff;
  logic nxt_count_up;
  logic [15:0] cmp_buf_ff [2];
  logic [15:0] cmp_act_ff [2];
  logic [15:0] capture_ff;
  logic [2:0] flags_ff;
  logic [2:0] nxt_flags;
  logic [9:0] pre_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_mux;

  // reset release through two flops; only the second is used
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n <= rst_meta_ff;
    end
  end

  // apb decode; the slave never waits
  logic setup_ph;
  logic access_ph;
  logic addr_hit;
  logic wr_en;
  logic wr_out_mode;
  logic wr_clk_mode;
  logic wr_counter;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_capture;
  logic wr_flags;
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign addr_hit = (paddr == ADDR_OUT_MODE) || (paddr == ADDR_CLK_MODE) || (paddr == ADDR_COUNTER) ||
                    (paddr == ADDR_CMP_A) || (paddr == ADDR_CMP_B) || (paddr == ADDR_CAPTURE) ||
                    (paddr == ADDR_FLAGS);
  assign pready = 1'b1;
  assign pslverr = access_ph && !addr_hit;
  assign wr_en = access_ph && pwrite && addr_hit;
  assign wr_out_mode = wr_en && (paddr == ADDR_OUT_MODE);
  assign wr_clk_mode = wr_en && (paddr == ADDR_CLK_MODE);
  assign wr_counter = wr_en && (paddr == ADDR_COUNTER);
  assign wr_cmp_a = wr_en && (paddr == ADDR_CMP_A);
  assign wr_cmp_b = wr_en && (paddr == ADDR_CMP_B);
  assign wr_capture = wr_en && (paddr == ADDR_CAPTURE);
  assign wr_flags = wr_en && (paddr == ADDR_FLAGS);

  // mode fields; code joins the high bits of the second register
  logic [3:0] mode_code;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] clk_sel;
  tcoc_family_type family;
  tcoc_topsrc_type topsrc;
  assign com_a = out_mode_ff[COM_A_LSB +: 2];
  assign com_b = out_mode_ff[COM_B_LSB +: 2];
  assign clk_sel = clk_mode_ff[CLK_SEL_LSB +: 3];
  assign mode_code = {clk_mode_ff[WGM_HIGH_LSB +: 2], out_mode_ff[WGM_LOW_LSB +: 2]};
  assign family = tcoc_family(mode_code);
  assign topsrc = tcoc_topsrc(mode_code);

  // TOP value of the current mode
  logic [15:0] top_fixed;
  logic [15:0] top;
  assign top_fixed = (mode_code[1:0] == 2'h1) ? TOP_8BIT :
                     (mode_code[1:0] == 2'h2) ? TOP_9BIT : TOP_10BIT;
  assign top = (topsrc == TOP_FIXED) ? top_fixed :
               (topsrc == TOP_CAPTURE) ? capture_ff :
               (topsrc == TOP_CMP_A) ? cmp_act_ff[0] : CNT_MAX;

  // external clock pin: two flops before the edge detector reads it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_last_ff <= 1'b0;
    end else begin
      ext_meta_ff <= ext_clk_pin;
      ext_sync_ff <= ext_meta_ff;
      ext_last_ff <= ext_sync_ff;
    end
  end

  // prescaler runs only while a source is chosen
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 10'h000;
    end else if (clk_sel == 3'h0) begin
      pre_ff <= 10'h000;
    end else begin
      pre_ff <= pre_ff + 10'h001;
    end
  end

  // timer tick: a one-cycle enable, never a clock of its own
  logic tick;
  assign tick = (clk_sel == 3'h1) ? 1'b1 :
                (clk_sel == 3'h2) ? ((pre_ff & PRE_MASK_8) == PRE_MASK_8) :
                (clk_sel == 3'h3) ? ((pre_ff & PRE_MASK_64) == PRE_MASK_64) :
                (clk_sel == 3'h4) ? ((pre_ff & PRE_MASK_256) == PRE_MASK_256) :
                (clk_sel == 3'h5) ? ((pre_ff & PRE_MASK_1024) == PRE_MASK_1024) :
                (clk_sel == 3'h6) ? (ext_last_ff && !ext_sync_ff) :
                (clk_sel == 3'h7) ? (!ext_last_ff && ext_sync_ff) : 1'b0;

  // count sequence per family
  logic at_top;
  logic at_bottom;
  logic dual;
  assign at_top = (counter_ff == top);
  assign at_bottom = (counter_ff == CNT_BOTTOM);
  assign dual = (family == FAM_PC) || (family == FAM_PFC);
  always_comb begin
    nxt_counter = counter_ff;
    nxt_count_up = count_up_ff;
    if (wr_counter) begin
      nxt_counter = pwdata[15:0];
    end else if (tick) begin
      if (family == FAM_NORMAL) begin
        nxt_counter = counter_ff + 16'h0001;
        nxt_count_up = 1'b1;
      end else if (!dual) begin
        nxt_counter = at_top ? CNT_BOTTOM : counter_ff + 16'h0001;
        nxt_count_up = 1'b1;
      end else if (count_up_ff) begin
        nxt_counter = at_top ? counter_ff - 16'h0001 : counter_ff + 16'h0001;
        nxt_count_up = !at_top;
      end else begin
        nxt_counter = at_bottom ? counter_ff + 16'h0001 : counter_ff - 16'h0001;
        nxt_count_up = at_bottom;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_ff <= WORD_RESET;
      count_up_ff <= 1'b1;
    end else begin
      counter_ff <= nxt_counter;
      count_up_ff <= nxt_count_up;
    end
  end

  // control registers; reserved bits never store
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_mode_ff <= OUT_MODE_RESET;
      clk_mode_ff <= CLK_MODE_RESET;
      capture_ff <= WORD_RESET;
    end else begin
      if (wr_out_mode) out_mode_ff <= pwdata[7:0] & OUT_MODE_MASK;
      if (wr_clk_mode) clk_mode_ff <= pwdata[7:0] & CLK_MODE_MASK;
      if (wr_capture) capture_ff <= pwdata[15:0];
    end
  end

  // compare buffers: immediate in non-PWM, at TOP, or at BOTTOM
  logic load_act;
  assign load_act = (family == FAM_NORMAL) || (family == FAM_CTC) ||
                    (tick && (family == FAM_PFC) && at_bottom) ||
                    (tick && ((family == FAM_FAST) || (family == FAM_PC)) && at_top);

  // per-channel compare storage and waveform units
  logic [1:0] com_sel [2];
  logic [1:0] match_w;
  logic [1:0] conn_w;
  logic [1:0] wave_w;
  logic [1:0] wr_cmp;
  assign com_sel[0] = com_a;
  assign com_sel[1] = com_b;
  assign wr_cmp = {wr_cmp_b, wr_cmp_a};

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        cmp_buf_ff[ch] <= WORD_RESET;
        cmp_act_ff[ch] <= WORD_RESET;
      end else begin
        if (wr_cmp[ch]) cmp_buf_ff[ch] <= pwdata[15:0];
        if (load_act) cmp_act_ff[ch] <= cmp_buf_ff[ch];
      end
    end

    tcoc_wave_chan #(
      .IS_CHAN_A(ch == 0)
    ) u_chan (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .tick(tick),
      .family(family),
      .mode_code(mode_code),
      .out_mode(com_sel[ch]),
      .counter(counter_ff),
      .compare(cmp_act_ff[ch]),
      .top(top),
      .count_up(count_up_ff),
      .match(match_w[ch]),
      .connect(conn_w[ch]),
      .wave_ff(wave_w[ch])
    );
  end

  // pin muxes; the pin driver itself is gated by software direction
  assign wave_out_a = wave_w[0];
  assign wave_out_b = wave_w[1];
  assign wave_connect_a = conn_w[0];
  assign wave_connect_b = conn_w[1];
  assign pin_out_a = conn_w[0] ? wave_w[0] : port_data_a;
  assign pin_out_b = conn_w[1] ? wave_w[1] : port_data_b;

  // event flags: write one to clear, a new event beats the clear
  logic ovf_event;
  logic [2:0] flag_set;
  assign ovf_event = tick && (((family == FAM_FAST) && at_top) ||
                              (dual && at_bottom && !count_up_ff) ||
                              (((family == FAM_NORMAL) || (family == FAM_CTC)) && (counter_ff == CNT_MAX)));
  assign flag_set = {ovf_event, tick && match_w[1], tick && match_w[0]};
  assign nxt_flags = (flags_ff & ~(wr_flags ? pwdata[2:0] : 3'h0)) | flag_set;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= 3'h0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // read data captured in the setup phase so prdata leaves a flop
  assign rd_mux = (paddr == ADDR_OUT_MODE) ? {24'h000000, out_mode_ff} :
                  (paddr == ADDR_CLK_MODE) ? {24'h000000, clk_mode_ff} :
                  (paddr == ADDR_COUNTER) ? {16'h0000, counter_ff} :
                  (paddr == ADDR_CMP_A) ? {16'h0000, cmp_buf_ff[0]} :
                  (paddr == ADDR_CMP_B) ? {16'h0000, cmp_buf_ff[1]} :
                  (paddr == ADDR_CAPTURE) ? {16'h0000, capture_ff} :
                  (paddr == ADDR_FLAGS) ? {29'h0, flags_ff} : 32'h00000000;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= rd_mux;
    end
  end
  assign prdata = prdata_ff;

  // checks on the design's own behaviour
  logic fast_m;
  assign fast_m = (family == FAM_FAST);

  a_reserved_bits_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_out_mode |=> (out_mode_ff == ($past(pwdata[7:0]) & OUT_MODE_MASK)) && (out_mode_ff[3:2] == 2'h0))
    else $error("reserved control bits stored a write");

  a_tick_gates_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!tick && !wr_counter) |=> $stable(counter_ff))
    else $error("counter moved without a tick");

  a_pfc_load_bottom: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((family == FAM_PFC) && !(tick && at_bottom)) |=> $stable(cmp_act_ff[0]))
    else $error("frequency-correct compare loaded away from bottom");

  a_off_no_connect: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (com_a == 2'h0) |-> (!wave_connect_a && (pin_out_a == port_data_a)))
    else $error("channel A drives the pin while off");

  a_nonpwm_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((family == FAM_CTC) && tick && match_w[0] && (com_a == 2'h2)) |=> !wave_out_a)
    else $error("non-PWM clear on match failed");

  a_fast_top_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fast_m && tick && at_top && (com_a == 2'h2) && (com_a == $past(com_a))) |=> wave_out_a)
    else $error("fast PWM did not set at TOP");

  a_fast_inverted_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fast_m && tick && match_w[0] && !at_top && (com_a == 2'h3)) |=> wave_out_a ##1 1'b1)
    else $error("inverted fast PWM did not set on match");

  a_fast_b_toggle_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fast_m && (com_b == 2'h1)) |-> !wave_connect_b)
    else $error("channel B connected in fast toggle mode");

  a_dual_toggle_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dual && (com_a == 2'h1) && (mode_code != CODE_PFC_CMPA) && (mode_code != CODE_FAST_CAP)) |-> !wave_connect_a)
    else $error("channel A toggle connected in wrong dual mode");

  a_dual_up_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dual && tick && count_up_ff && match_w[0] && !at_top && !at_bottom && (com_a == 2'h2)) |=> !wave_out_a)
    else $error("dual-slope upcount match did not clear");

  a_dual_down_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (dual && tick && !count_up_ff && match_w[0] && !at_top && !at_bottom && (com_a == 2'h3)) |=> !wave_out_a)
    else $error("inverted dual-slope downcount match did not clear");

  a_match_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && match_w[0]) |=> flags_ff[FLAG_MATCH_A])
    else $error("match flag not set after tick at equality");

  a_fixed_top_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_code == 4'h6) |-> (top == TOP_9BIT))
    else $error("fixed TOP wrong for 9-bit fast PWM");

  a_capture_top: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_code == CODE_FAST_CAP) |-> (top == capture_ff))
    else $error("capture register not used as TOP");

  c_fast_pwm_top: cover property (@(posedge sys_clk) disable iff (!rst_n)
    fast_m && tick && at_top && (com_a == 2'h2));
  c_dual_turn: cover property (@(posedge sys_clk) disable iff (!rst_n)
    dual && tick && at_top && count_up_ff);
  c_pfc_reload: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (family == FAM_PFC) && tick && at_bottom && (cmp_buf_ff[0] != cmp_act_ff[0]));
  c_flag_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_flags && (flags_ff != 3'h0));

endmodule

`default_nettype wire

// File: timer16_compare_output_control_bench.sv
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module timer16_compare_output_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcoc_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic port_data_a = 1'b0;
  logic port_data_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, wave_out_a, wave_out_b, wave_connect_a, wave_connect_b, pin_out_a, pin_out_b;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] mdl [logic [7:0]];
  logic [31:0] rd;
  logic err;
  int n, t, c, cb, lows;

  tcoc_timer16 dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_pin(ext_clk_pin), .port_data_a(port_data_a), .port_data_b(port_data_b),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .wave_connect_a(wave_connect_a),
    .wave_connect_b(wave_connect_b), .pin_out_a(pin_out_a), .pin_out_b(pin_out_b));

  // free-running 200 MHz clock
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no fixed wait count: only the watchdog ends a stalled access
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register model keeps only the writable bits of each mapped word
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    mdl[a] = d & ((a == ADDR_OUT_MODE) ? 32'h0000_00F3 : (a == ADDR_CLK_MODE) ? 32'h0000_001F : 32'h0000_FFFF);
  endtask

  task automatic cfg(input logic [3:0] code, input logic [1:0] oma, input logic [1:0] omb, input logic [2:0] sel);
    wr(ADDR_CLK_MODE, {27'h0, code[3:2], 3'h0});
    wr(ADDR_OUT_MODE, {24'h0, oma, omb, 2'b00, code[1:0]});
    wr(ADDR_COUNTER, 32'h0000_0000);
    wr(ADDR_CLK_MODE, {27'h0, code[3:2], sel});
  endtask

  function automatic logic sig(input bit ch);
    return ch ? wave_out_b : wave_out_a;
  endfunction

  // length in cycles of the next whole stretch at level lvl
  task automatic pulse(input bit ch, input logic lvl, output int len);
    int g;
    len = 0;
    for (g = 0; g < 3000 && sig(ch) === lvl; g++) @(posedge sys_clk);
    for (g = 0; g < 3000 && sig(ch) !== lvl; g++) @(posedge sys_clk);
    for (g = 0; g < 3000 && sig(ch) === lvl; g++) begin
      @(posedge sys_clk);
      len++;
    end
  endtask

  // watchdog: the scenarios take a few thousand cycles, so this leaves ample margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(26));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    xfer(1'b0, ADDR_OUT_MODE, 32'h0);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, ADDR_CLK_MODE, 32'h0);
    `CHK(rd, 32'h0000_0000)
    wr(ADDR_OUT_MODE, $urandom);
    xfer(1'b0, ADDR_OUT_MODE, 32'h0);
    `CHK(rd, mdl[ADDR_OUT_MODE])
    xfer(1'b1, 8'h40, $urandom);
    `CHK(err, 1'b1)
    xfer(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0000_0000)
    // pin ownership for every mode code and output mode, counter stopped
    for (int code = 0; code < 16; code++) begin
      for (int om = 0; om < 4; om++) begin
        cfg(code[3:0], om[1:0], om[1:0], 3'h0);
        port_data_a <= 1'($urandom);
        port_data_b <= 1'($urandom);
        @(posedge sys_clk);
        @(negedge sys_clk);
        c = (om > 1) || (om == 1 && (code inside {0, 4, 9, 12, 13, 15}));
        cb = (om > 1) || (om == 1 && (code inside {0, 4, 12, 13}));
        `CHK(wave_connect_a, 1'(c))
        `CHK(wave_connect_b, 1'(cb))
        `CHK(pin_out_a, c ? wave_out_a : port_data_a)
        `CHK(pin_out_b, cb ? wave_out_b : port_data_b)
      end
    end
    // clear-on-compare with channel A compare as TOP
    t = 3 + $urandom % 20;
    wr(ADDR_CMP_A, t);
    wr(ADDR_CMP_B, 32'h1);
    cfg(4'h4, 2'b01, 2'b11, 3'h1);
    pulse(1'b0, 1'b1, n);
    `CHK(n, t + 1)
    pulse(1'b0, 1'b0, n);
    `CHK(n, t + 1)
    `CHK(wave_out_b, 1'b1)
    xfer(1'b0, ADDR_FLAGS, 32'h0);
    `CHK(rd[FLAG_MATCH_A], 1'b1)
    // fast pwm with capture register as TOP
    t = 20 + $urandom % 30;
    c = 1 + $urandom % (t - 1);
    cb = 1 + $urandom % (t - 1);
    wr(ADDR_CAPTURE, t);
    wr(ADDR_CMP_A, c);
    wr(ADDR_CMP_B, cb);
    cfg(4'hE, 2'b10, 2'b11, 3'h1);
    pulse(1'b0, 1'b1, n);
    `CHK(n, c + 1)
    pulse(1'b1, 1'b0, n);
    `CHK(n, cb + 1)
    // compare at TOP: only the set at TOP acts, output stays high
    wr(ADDR_CMP_A, t);
    repeat (3 * t) @(posedge sys_clk);
    lows = 0;
    repeat (3 * t) begin
      @(posedge sys_clk);
      lows += (wave_out_a !== 1'b1);
    end
    `CHK(lows, 0)
    // dual-slope families: phase-correct then phase-and-frequency-correct
    for (int i = 0; i < 2; i++) begin
      c = 2 + $urandom % (t - 3);
      cb = 2 + $urandom % (t - 3);
      wr(ADDR_CMP_A, c);
      wr(ADDR_CMP_B, cb);
      cfg(i ? 4'h8 : 4'hA, 2'b10, 2'b11, 3'h1);
      pulse(1'b0, 1'b0, n);
      pulse(1'b0, 1'b0, n);
      `CHK(n, 2 * (t - c))
      pulse(1'b1, 1'b1, n);
      `CHK(n, 2 * (t - cb))
    end
    // prescaler /8: two reads exactly 64 cycles apart see eight ticks
    cfg(4'h0, 2'b00, 2'b00, 3'h2);
    xfer(1'b0, ADDR_COUNTER, 32'h0);
    n = rd;
    repeat (61) @(posedge sys_clk);
    xfer(1'b0, ADDR_COUNTER, 32'h0);
    `CHK(rd - n, 32'h8)
    // external pin, falling then rising edge select: one count per chosen edge
    for (int s = 6; s < 8; s++) begin
      t = 1 + $urandom % 9;
      cfg(4'h0, 2'b00, 2'b00, s[2:0]);
      repeat (t) begin
        @(posedge sys_clk);
        ext_clk_pin <= ~ext_clk_pin;
        repeat (2) @(posedge sys_clk);
        ext_clk_pin <= ~ext_clk_pin;
        @(posedge sys_clk);
      end
      repeat (5) @(posedge sys_clk);
      xfer(1'b0, ADDR_COUNTER, 32'h0);
      `CHK(rd, t)
    end
    // pin idle so no tick can set a flag again; write ones to clear all
    wr(ADDR_FLAGS, 32'h7);
    xfer(1'b0, ADDR_FLAGS, 32'h0);
    `CHK(rd, 32'h0)
    tally_and_finish();
  end
endmodule
`default_nettype wire
